// >>> hw/usmc_top.sv
// Purpose: line configuration register and interrupt mask of a serial transceiver
// Assumes: Avalon-MM slave, one wait state per access, inputs synchronous to REF_CLK
// Notes:   decoded line configuration is exported for the serial datapath
//          the mask keeps one shared manchester bit; the alias position only mirrors it
//          status flags follow the channel layout, where the manchester error sits at
//          bit 24 while its enable sits at bit 20, so the interrupt path remaps it
//          write protect is a single bit of our own at its own offset
//          the clock divisor is a fixed constant, not a register field
//          reserved field codes give outputs that the datapath must not rely on
//          all state freezes while CLK_EN is low, the bus answer included
// How it works
// - clock output drives pin unless external source
// - nine-bit select else length 5 to 8
// - bit order sets LSB or MSB first
// - in SPI modes order bit is idle level
// - in SPI modes sync bit is phase
// - sync bit picks async or sync operation
// - channel path: normal, echo, local, remote loop
// - stop bits 1, 1.5 async, 2
// - parity even, odd, 0, 1, none, multidrop
// - clock source periph, divided, external
// - mode field selects protocol mode
// - enable-set writes ones into the mask
// - enable-clear writes ones out of mask
// - zero bits written leave mask unchanged
// - mask view reads enabled sources as one
// - both manchester positions control one bit
// - both manchester positions read shared bit
// - write protect blocks line config writes
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/100ps
module usmc_top
    import usmc_pkg::*;
(
    // clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RSTN,
    input  wire logic        CLK_EN,
    // avalon-mm slave
    input  wire logic [7:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    // status flags from the channel
    input  wire logic [31:0] STATUS_FLAGS,
    // serial clock pin
    input  wire logic        SCLK_IN,
    output logic             SCLK_OUT,
    output logic             SCLK_OE_N,
    // decoded configuration
    output logic [3:0]       CHAR_BITS,
    output logic             MSB_FIRST,
    output logic             SCLK_IDLE_LEVEL,
    output logic             SCLK_PHASE,
    output logic             SYNC_OP,
    output logic             SPI_OP,
    output logic [1:0]       CHANNEL_PATH,
    output logic [1:0]       STOP_HALVES,
    output logic             PARITY_EN,
    output logic             PARITY_FIXED,
    output logic             PARITY_VALUE,
    output logic             MULTIDROP,
    output logic [3:0]       PROTO_MODE,
    output logic             OVERSAMPLE_8,
    output logic             SRC_CLK_EN,
    // interrupt
    output logic             IRQ
);
    import usmc_pkg::*;

    usmc_bus_t   bus_q, bus_d;
    logic [31:0] cfg_q, cfg_d;
    logic [31:0] mask_q, mask_d;
    logic        wprot_q, wprot_d;
    logic [31:0] rdata_q, rdata_d;
    logic [3:0]  div_q, div_d;
    logic        sclk_q, sclk_d;
    logic        irq_q, irq_d;
    logic [31:0] irq_src;
    logic [31:0] wmask;
    logic        fire;
    logic        spi_mode;

    // merge the two manchester positions onto the shared bit
    function automatic logic [31:0] fold_manchester_err_enable(input logic [31:0] v);
        logic [31:0] r;
        r = v & USMC_IRQ_IMPL;
        r[USMC_MANCHESTER_ERR_ENABLE_BIT] = v[USMC_MANCHESTER_ERR_ENABLE_BIT] | v[USMC_MANCHESTER_ERR_ENABLE_ALIAS_BIT];
        r[USMC_MANCHESTER_ERR_ENABLE_ALIAS_BIT] = 1'b0;
        return r;
    endfunction

    // expand byte enables to a bit mask
    function automatic logic [31:0] be_mask(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    assign wmask    = be_mask(AVS_BYTEENABLE);
    assign fire     = (bus_q == USMC_BUS_ACK);
    assign spi_mode = (cfg_q[USMC_MODE_LSB +: 4] == USMC_MODE_SPI_M) ||
                      (cfg_q[USMC_MODE_LSB +: 4] == USMC_MODE_SPI_S);

    // bus answer: one wait cycle, then the access completes
    // the access acts on the first edge and is acknowledged on the second,
    // so a master that holds its request until waitrequest falls sees
    // read data that was loaded one edge earlier and stands unchanged
    assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !fire;
    assign AVS_READDATA    = rdata_q;

    // register next values
    always_comb begin
        bus_d   = bus_q;
        cfg_d   = cfg_q;
        mask_d  = mask_q;
        wprot_d = wprot_q;
        rdata_d = rdata_q;
        if (fire) begin
            bus_d = USMC_BUS_IDLE;
        end else if (AVS_READ || AVS_WRITE) begin
            bus_d = USMC_BUS_ACK;
            if (AVS_WRITE) begin
                case (AVS_ADDRESS)
                    USMC_OFS_LINE_CFG: begin
                        if (!wprot_q) begin
                            cfg_d = (cfg_q & ~wmask) | (AVS_WRITEDATA & wmask);
                        end
                    end
                    USMC_OFS_IRQ_SET: begin
                        mask_d = mask_q | fold_manchester_err_enable(AVS_WRITEDATA & wmask);
                    end
                    USMC_OFS_IRQ_CLR: begin
                        mask_d = mask_q & ~fold_manchester_err_enable(AVS_WRITEDATA & wmask);
                    end
                    USMC_OFS_WPROT: begin
                        if (AVS_BYTEENABLE[0]) begin
                            wprot_d = AVS_WRITEDATA[0];
                        end
                    end
                    default: begin
                    end
                endcase
            end else begin
                case (AVS_ADDRESS)
                    USMC_OFS_LINE_CFG: rdata_d = cfg_q;
                    USMC_OFS_IRQ_VIEW: begin
                        rdata_d = mask_q;
                        rdata_d[USMC_MANCHESTER_ERR_ENABLE_ALIAS_BIT] = mask_q[USMC_MANCHESTER_ERR_ENABLE_BIT];
                    end
                    USMC_OFS_CHAN_ST:  rdata_d = STATUS_FLAGS;
                    USMC_OFS_WPROT:    rdata_d = {31'h0000_0000, wprot_q};
                    default:           rdata_d = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            bus_q   <= USMC_BUS_IDLE;
            cfg_q   <= USMC_LINE_CFG_RST;
            mask_q  <= USMC_IRQ_RST;
            wprot_q <= USMC_WPROT_RST;
            rdata_q <= 32'h0000_0000;
        end else if (CLK_EN) begin
            bus_q   <= bus_d;
            cfg_q   <= cfg_d;
            mask_q  <= mask_d;
            wprot_q <= wprot_d;
            rdata_q <= rdata_d;
        end
    end

    // clock source tick and serial clock output
    always_comb begin
        div_d  = div_q;
        sclk_d = sclk_q;
        // the manchester enable guards the error flag at the alias position;
        // the flag at the shared position belongs to no interrupt source
        irq_src                 = mask_q & USMC_IRQ_IMPL;
        irq_src[USMC_MANCHESTER_ERR_ENABLE_ALIAS_BIT] = mask_q[USMC_MANCHESTER_ERR_ENABLE_BIT];
        irq_src[USMC_MANCHESTER_ERR_ENABLE_BIT]  = 1'b0;
        irq_d  = |(STATUS_FLAGS & irq_src);
        case (cfg_q[USMC_CLKSRC_LSB +: 2])
            USMC_CLK_DIV: begin
                div_d = (div_q == USMC_CLK_DIVISOR - 4'h1) ? 4'h0 : div_q + 4'h1;
            end
            default: div_d = 4'h0;
        endcase
        if (spi_mode && !cfg_q[USMC_CLOCK_PIN_DRIVE_BIT]) begin
            sclk_d = cfg_q[USMC_ORDER_BIT];
        end else begin
            sclk_d = SCLK_IN;
        end
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            div_q  <= 4'h0;
            sclk_q <= 1'b0;
            irq_q  <= 1'b0;
        end else if (CLK_EN) begin
            div_q  <= div_d;
            sclk_q <= sclk_d;
            irq_q  <= irq_d;
        end
    end

    // serial clock pin drive
    // the pin is never driven while the external source is selected, so the
    // block cannot fight a clock that comes from outside
    assign SCLK_OUT  = sclk_q;
    assign SCLK_OE_N = !(cfg_q[USMC_CLOCK_PIN_DRIVE_BIT] &&
                         cfg_q[USMC_CLKSRC_LSB +: 2] != USMC_CLK_EXT);
    assign IRQ       = irq_q;

    // decoded configuration
    always_comb begin
        CHAR_BITS = cfg_q[USMC_NINE_BIT] ? 4'h9
                  : 4'h5 + {2'b00, cfg_q[USMC_CHAR_LEN_FIELD_LSB +: 2]};
        SPI_OP          = spi_mode;
        MSB_FIRST       = spi_mode ? 1'b1 : cfg_q[USMC_ORDER_BIT];
        SCLK_IDLE_LEVEL = spi_mode & cfg_q[USMC_ORDER_BIT];
        SCLK_PHASE      = spi_mode & cfg_q[USMC_SYNC_BIT];
        SYNC_OP         = spi_mode | cfg_q[USMC_SYNC_BIT];
        CHANNEL_PATH    = cfg_q[USMC_CHANNEL_PATH_SEL_LSB +: 2];
        case (cfg_q[USMC_STOP_BIT_COUNT_LSB +: 2])
            2'h0:    STOP_HALVES = 2'h2;
            2'h1:    STOP_HALVES = cfg_q[USMC_SYNC_BIT] ? 2'h2 : 2'h3;
            default: STOP_HALVES = 2'h0;
        endcase
        if (cfg_q[USMC_STOP_BIT_COUNT_LSB +: 2] == 2'h2) begin
            STOP_HALVES = 2'h0; // 4 halves encoded as zero
        end
        PARITY_EN    = !cfg_q[USMC_PAR_LSB + 2];
        PARITY_FIXED = !cfg_q[USMC_PAR_LSB + 2] & cfg_q[USMC_PAR_LSB + 1];
        PARITY_VALUE = cfg_q[USMC_PAR_LSB];
        MULTIDROP    = cfg_q[USMC_PAR_LSB + 2] & cfg_q[USMC_PAR_LSB + 1];
        PROTO_MODE   = cfg_q[USMC_MODE_LSB +: 4];
        OVERSAMPLE_8 = cfg_q[USMC_OVER_BIT];
        SRC_CLK_EN   = (cfg_q[USMC_CLKSRC_LSB +: 2] == USMC_CLK_PERIPH) ||
                       (cfg_q[USMC_CLKSRC_LSB +: 2] == USMC_CLK_DIV && div_q == 4'h0);
    end

    // checks
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);

    set_mask_a: assert property (!fire && CLK_EN && AVS_WRITE && AVS_ADDRESS == USMC_OFS_IRQ_SET
        |=> (mask_q & $past(mask_q)) == $past(mask_q))
        else $error("enable-set cleared a bit");
    set_bits_a: assert property (!fire && CLK_EN && AVS_WRITE && AVS_ADDRESS == USMC_OFS_IRQ_SET
        && AVS_BYTEENABLE == 4'hf |=> (mask_q & (AVS_WRITEDATA & USMC_IRQ_IMPL & ~(32'h1 << 24)))
        == ($past(AVS_WRITEDATA) & USMC_IRQ_IMPL & ~(32'h1 << 24)))
        else $error("mask bit not set");
    clr_bits_a: assert property (!fire && CLK_EN && AVS_WRITE && AVS_ADDRESS == USMC_OFS_IRQ_CLR
        && AVS_BYTEENABLE == 4'hf |=> (mask_q & $past(AVS_WRITEDATA)) == 32'h0)
        else $error("mask bit not cleared");
    zero_keep_a: assert property (!fire && CLK_EN && AVS_WRITE && AVS_WRITEDATA == 32'h0
        |=> $stable(mask_q))
        else $error("zero write changed mask");
    alias_read_a: assert property (fire && AVS_READ && AVS_ADDRESS == USMC_OFS_IRQ_VIEW
        |=> AVS_READDATA[USMC_MANCHESTER_ERR_ENABLE_ALIAS_BIT] == AVS_READDATA[USMC_MANCHESTER_ERR_ENABLE_BIT])
        else $error("manchester read positions differ");
    wprot_a: assert property (wprot_q && !fire && CLK_EN && AVS_WRITE
        && AVS_ADDRESS == USMC_OFS_LINE_CFG |=> $stable(cfg_q))
        else $error("protected config changed");
    pin_drive_a: assert property (cfg_q[USMC_CLKSRC_LSB +: 2] == USMC_CLK_EXT |-> SCLK_OE_N)
        else $error("pin driven on external clock");
    irq_a: assert property (CLK_EN && |(STATUS_FLAGS & irq_src) |=> IRQ)
        else $error("interrupt missing");
    char_a: assert property (cfg_q[USMC_NINE_BIT] |-> CHAR_BITS == 4'h9)
        else $error("nine-bit length wrong");
    // a one at the alias position sets the shared manchester bit
    manchester_err_enable_set_a: assert property (!fire && CLK_EN && AVS_WRITE && AVS_ADDRESS == USMC_OFS_IRQ_SET
        && AVS_BYTEENABLE[3] && AVS_WRITEDATA[USMC_MANCHESTER_ERR_ENABLE_ALIAS_BIT] |=> mask_q[USMC_MANCHESTER_ERR_ENABLE_BIT])
        else $error("alias set ignored");
    // a one at the alias position clears the shared manchester bit
    manchester_err_enable_clr_a: assert property (!fire && CLK_EN && AVS_WRITE && AVS_ADDRESS == USMC_OFS_IRQ_CLR
        && AVS_BYTEENABLE[3] && AVS_WRITEDATA[USMC_MANCHESTER_ERR_ENABLE_ALIAS_BIT] |=> !mask_q[USMC_MANCHESTER_ERR_ENABLE_BIT])
        else $error("alias clear ignored");
    // only the set and clear registers move the mask
    mask_hold_a: assert property (!(!fire && AVS_WRITE && (AVS_ADDRESS == USMC_OFS_IRQ_SET ||
        AVS_ADDRESS == USMC_OFS_IRQ_CLR)) |=> $stable(mask_q))
        else $error("mask moved without a set or clear");
    // clock output on an internal source drives the pin
    pin_on_a: assert property (cfg_q[USMC_CLOCK_PIN_DRIVE_BIT] && cfg_q[USMC_CLKSRC_LSB +: 2] != USMC_CLK_EXT
        |-> !SCLK_OE_N)
        else $error("pin not driven");
    // clock output off leaves the pin undriven
    pin_off_a: assert property (!cfg_q[USMC_CLOCK_PIN_DRIVE_BIT]
        |-> SCLK_OE_N)
        else $error("pin driven with output off");
    // length field picks five to eight bits
    char_len_a: assert property (!cfg_q[USMC_NINE_BIT]
        |-> CHAR_BITS == 4'h5 + {2'b00, cfg_q[USMC_CHAR_LEN_FIELD_LSB +: 2]})
        else $error("character length wrong");
    // bit order follows the order bit outside the spi modes
    bit_order_a: assert property (!spi_mode
        |-> MSB_FIRST == cfg_q[USMC_ORDER_BIT])
        else $error("bit order wrong");
    // an undriven spi clock rests at the idle level
    spi_idle_a: assert property (spi_mode && !cfg_q[USMC_CLOCK_PIN_DRIVE_BIT] && CLK_EN
        |=> SCLK_OUT == $past(cfg_q[USMC_ORDER_BIT]))
        else $error("spi clock not at idle level");
    // phase and polarity come from the shared bit positions
    spi_phase_a: assert property (spi_mode
        |-> SCLK_PHASE == cfg_q[USMC_SYNC_BIT] && SCLK_IDLE_LEVEL == cfg_q[USMC_ORDER_BIT])
        else $error("spi phase or polarity wrong");
    // sync bit picks the operating style outside spi
    sync_sel_a: assert property (!spi_mode
        |-> SYNC_OP == cfg_q[USMC_SYNC_BIT])
        else $error("sync select wrong");
    // channel path is the field itself
    path_sel_a: assert property (1'b1
        |-> CHANNEL_PATH == cfg_q[USMC_CHANNEL_PATH_SEL_LSB +: 2])
        else $error("channel path wrong");
    // code zero gives one stop bit
    stop_one_a: assert property (cfg_q[USMC_STOP_BIT_COUNT_LSB +: 2] == 2'h0
        |-> STOP_HALVES == 2'h2)
        else $error("one stop bit wrong");
    // code one gives one and a half stop bits when asynchronous
    stop_half_a: assert property (cfg_q[USMC_STOP_BIT_COUNT_LSB +: 2] == 2'h1 && !cfg_q[USMC_SYNC_BIT]
        |-> STOP_HALVES == 2'h3)
        else $error("half stop bit wrong");
    // upper parity bit set means no parity bit on the line
    parity_off_a: assert property (cfg_q[USMC_PAR_LSB + 2]
        |-> !PARITY_EN)
        else $error("parity not off");
    // both upper parity bits select multidrop
    multidrop_a: assert property (1'b1
        |-> MULTIDROP == (cfg_q[USMC_PAR_LSB + 2] && cfg_q[USMC_PAR_LSB + 1]))
        else $error("multidrop decode wrong");
    // the external source gives no internal tick
    ext_tick_a: assert property (cfg_q[USMC_CLKSRC_LSB +: 2] == USMC_CLK_EXT
        |-> !SRC_CLK_EN)
        else $error("tick on external source");
    // protocol mode is the field itself
    mode_sel_a: assert property (1'b1
        |-> PROTO_MODE == cfg_q[USMC_MODE_LSB +: 4])
        else $error("protocol mode wrong");
    // no enabled active flag, no interrupt
    irq_quiet_a: assert property (CLK_EN && !(|(STATUS_FLAGS & irq_src))
        |=> !IRQ)
        else $error("spurious interrupt");

    cov_set_c:  cover property (AVS_WRITE && fire && AVS_ADDRESS == USMC_OFS_IRQ_SET);
    cov_irq_c:  cover property (IRQ);
    cov_spi_c:  cover property (spi_mode && !SCLK_OE_N);
    cov_prot_c: cover property (wprot_q && AVS_WRITE && AVS_ADDRESS == USMC_OFS_LINE_CFG);
    // divided source producing a tick
    cov_div_c:  cover property (cfg_q[USMC_CLKSRC_LSB +: 2] == USMC_CLK_DIV && SRC_CLK_EN);
endmodule

// >>> hw/usmc_pkg.sv
// Purpose: constants for the serial line configuration and interrupt mask block
// Assumes: 32-bit register bus, word-aligned byte offsets
// Notes:   offsets are byte addresses
package usmc_pkg;
    // register byte offsets
    localparam logic [7:0] USMC_OFS_LINE_CFG  = 8'h04;
    localparam logic [7:0] USMC_OFS_IRQ_SET   = 8'h08;
    localparam logic [7:0] USMC_OFS_IRQ_CLR   = 8'h0c;
    localparam logic [7:0] USMC_OFS_IRQ_VIEW  = 8'h10;
    localparam logic [7:0] USMC_OFS_CHAN_ST   = 8'h14;
    localparam logic [7:0] USMC_OFS_WPROT     = 8'he4;
    // line_config field positions
    localparam int USMC_MODE_LSB    = 0;
    localparam int USMC_CLKSRC_LSB  = 4;
    localparam int USMC_CHAR_LEN_FIELD_LSB    = 6;
    localparam int USMC_SYNC_BIT    = 8;
    localparam int USMC_PAR_LSB     = 9;
    localparam int USMC_STOP_BIT_COUNT_LSB  = 12;
    localparam int USMC_CHANNEL_PATH_SEL_LSB  = 14;
    localparam int USMC_ORDER_BIT   = 16;
    localparam int USMC_NINE_BIT    = 17;
    localparam int USMC_CLOCK_PIN_DRIVE_BIT    = 18;
    localparam int USMC_OVER_BIT    = 19;
    // mask layout
    localparam int USMC_MANCHESTER_ERR_ENABLE_BIT    = 20;
    localparam int USMC_MANCHESTER_ERR_ENABLE_ALIAS_BIT   = 24;
    localparam logic [31:0] USMC_IRQ_IMPL = 32'h011f_3727;
    // reset values
    localparam logic [31:0] USMC_LINE_CFG_RST = 32'h0000_0000;
    localparam logic [31:0] USMC_IRQ_RST      = 32'h0000_0000;
    localparam logic        USMC_WPROT_RST    = 1'b0;
    // protocol mode codes
    localparam logic [3:0] USMC_MODE_NORMAL = 4'h0;
    localparam logic [3:0] USMC_MODE_RS485  = 4'h1;
    localparam logic [3:0] USMC_MODE_HSHK   = 4'h2;
    localparam logic [3:0] USMC_MODE_MODEM  = 4'h3;
    localparam logic [3:0] USMC_MODE_ISO_T0 = 4'h4;
    localparam logic [3:0] USMC_MODE_ISO_T1 = 4'h6;
    localparam logic [3:0] USMC_MODE_IRDA   = 4'h8;
    localparam logic [3:0] USMC_MODE_SPI_M  = 4'he;
    localparam logic [3:0] USMC_MODE_SPI_S  = 4'hf;
    // clock sources
    localparam logic [1:0] USMC_CLK_PERIPH = 2'h0;
    localparam logic [1:0] USMC_CLK_DIV    = 2'h1;
    localparam logic [1:0] USMC_CLK_EXT    = 2'h3;
    // clock divisor for the divided source, arbitrary default
    localparam logic [3:0] USMC_CLK_DIVISOR = 4'h8;
    // bus answer states
    typedef enum logic [1:0] {
        USMC_BUS_IDLE = 2'b01,
        USMC_BUS_ACK  = 2'b10
    } usmc_bus_t;
endpackage

// >>> tb/usmc_peer.sv
// Purpose: remote serial peer on the shared serial clock line
// Assumes: peer clock toggles on every rising REF_CLK edge while running
// Notes:   the line parks at the idle level between frames
`timescale 1ns/100ps
module usmc_peer (
    // clock and control
    input  wire logic clk,
    input  wire logic run,
    input  wire logic idle,
    // line level
    output logic      lvl
);
    // toggle inside a frame, rest at the idle level outside
    always_ff @(posedge clk) begin
        if (run) begin
            lvl <= !lvl;
        end else begin
            lvl <= idle;
        end
    end
endmodule

// >>> tb/tb_usart_mode_and_irq_mask.sv
// Purpose: self-checking bench for line config and interrupt mask
// Assumes: avalon master waits for waitrequest low before release
// Notes:   expectations come from field positions only
`timescale 1ns/100ps
module tb_usart_mode_and_irq_mask;
    import usmc_pkg::*;
    logic        clk, rstn, rd, wr, wait_rq, sclk, sclk_out, oe_n, msb, idle, phase, sync_op, spi;
    logic        par_en, par_fix, par_val, mdrop, over8, src_en, irq, peer_run, peer_lvl;
    logic [7:0]  adr;
    logic [31:0] wdat, rdat, flags, r;
    logic [3:0]  cbits, proto;
    logic [1:0]  path, stop_h;
    logic [3:0]  codes [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'he, 4'hf}; // legal codes only
    int          bad_count, n_compared, cyc;

    usmc_top usmc_top_i (.REF_CLK(clk), .RSTN(rstn), .CLK_EN(1'b1), .AVS_ADDRESS(adr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat),
        .AVS_WAITREQUEST(wait_rq), .STATUS_FLAGS(flags), .SCLK_IN(sclk), .SCLK_OUT(sclk_out),
        .SCLK_OE_N(oe_n), .CHAR_BITS(cbits), .MSB_FIRST(msb), .SCLK_IDLE_LEVEL(idle), .SCLK_PHASE(phase),
        .SYNC_OP(sync_op), .SPI_OP(spi), .CHANNEL_PATH(path), .STOP_HALVES(stop_h), .PARITY_EN(par_en),
        .PARITY_FIXED(par_fix), .PARITY_VALUE(par_val), .MULTIDROP(mdrop), .PROTO_MODE(proto),
        .OVERSAMPLE_8(over8), .SRC_CLK_EN(src_en), .IRQ(irq));
    usmc_peer usmc_peer_i (.clk(clk), .run(peer_run), .idle(1'b0), .lvl(peer_lvl));
    // shared clock pin: the block wins while its enable is low
    assign sclk = (oe_n === 1'b0) ? sclk_out : peer_lvl;

    // clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic print_verdict();
        if (bad_count == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one bus access, held until waitrequest is sampled low
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wdat <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clk);
        end while (wait_rq !== 1'b0);
        r = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(r, e);
    endtask
    task automatic cfg(input logic [31:0] v);
        xfer(1'b1, USMC_OFS_LINE_CFG, v);
    endtask
    // counts source ticks over sixteen cycles
    task automatic ticks(input int e);
        int n;
        n = 0;
        repeat (16) begin
            @(posedge clk);
            n += int'(src_en === 1'b1);
        end
        chk(32'(n), 32'(e));
    endtask
    task automatic t_mask();
        rchk(USMC_OFS_IRQ_VIEW, 32'h0);
        rchk(USMC_OFS_IRQ_SET, 32'h0);
        rchk(8'h30, 32'h0);
        xfer(1'b1, USMC_OFS_IRQ_SET, USMC_IRQ_IMPL);
        rchk(USMC_OFS_IRQ_VIEW, USMC_IRQ_IMPL);
        xfer(1'b1, USMC_OFS_IRQ_SET, 32'h0);
        xfer(1'b1, USMC_OFS_IRQ_CLR, 32'h0);
        rchk(USMC_OFS_IRQ_VIEW, USMC_IRQ_IMPL);
        xfer(1'b1, USMC_OFS_IRQ_CLR, 32'h5);
        rchk(USMC_OFS_IRQ_VIEW, USMC_IRQ_IMPL & ~32'h5);
        xfer(1'b1, USMC_OFS_IRQ_CLR, 32'h0100_0000);
        rchk(USMC_OFS_IRQ_VIEW, USMC_IRQ_IMPL & ~32'h0110_0005);
        xfer(1'b1, USMC_OFS_IRQ_SET, 32'h0010_0000);
        rchk(USMC_OFS_IRQ_VIEW, USMC_IRQ_IMPL & ~32'h5);
        xfer(1'b1, USMC_OFS_IRQ_CLR, 32'hffff_ffff);
        xfer(1'b1, USMC_OFS_IRQ_SET, 32'h1);
        flags <= 32'h2;
        repeat (3) @(posedge clk);
        chk(irq, 1'b0);
        flags <= 32'h3;
        repeat (3) @(posedge clk);
        chk(irq, 1'b1);
        rchk(USMC_OFS_CHAN_ST, 32'h3);
        xfer(1'b1, USMC_OFS_IRQ_CLR, 32'h1);
        repeat (3) @(posedge clk);
        chk(irq, 1'b0);
        xfer(1'b1, USMC_OFS_IRQ_SET, 32'h0100_0000);
        flags <= 32'h0100_0000;
        repeat (3) @(posedge clk);
        chk(irq, 1'b1);
    endtask
    task automatic t_fields();
        for (int i = 0; i < 8; i++) begin
            cfg((32'(i) << USMC_PAR_LSB) | (32'(i % 4) << USMC_CHAR_LEN_FIELD_LSB) | (32'(i % 4) << USMC_CHANNEL_PATH_SEL_LSB));
            chk(cbits, 32'(5 + i % 4));
            chk(path, 32'(i % 4));
            chk(par_en, 32'(i < 4));
            chk(mdrop, 32'(i >= 6));
            if (i < 4) chk({par_fix, par_val}, 32'(i));
        end
        cfg(32'h1 << USMC_NINE_BIT);
        chk(cbits, 32'h9);
        for (int i = 0; i < 3; i++) begin
            cfg(32'(i) << USMC_STOP_BIT_COUNT_LSB);
            chk(stop_h, (i == 0) ? 32'h2 : (i == 1) ? 32'h3 : 32'h0);
        end
        foreach (codes[k]) begin
            cfg(32'(codes[k]) | (32'h1 << USMC_ORDER_BIT));
            chk(proto, 32'(codes[k]));
            chk(spi, 32'(codes[k] >= 4'he));
            chk(idle, 32'(codes[k] >= 4'he));
        end
        cfg((32'h1 << USMC_ORDER_BIT) | (32'h1 << USMC_OVER_BIT));
        chk({msb, sync_op, over8}, 32'h5);
        cfg(32'h1 << USMC_SYNC_BIT);
        chk({msb, sync_op}, 32'h1);
        cfg(32'(USMC_MODE_SPI_S) | (32'h1 << USMC_SYNC_BIT));
        chk({idle, phase}, 32'h1);
        cfg(32'(USMC_MODE_SPI_M) | (32'h1 << USMC_ORDER_BIT));
        chk({idle, phase}, 32'h2);
    endtask
    task automatic t_clock();
        cfg(32'h1 << USMC_CLOCK_PIN_DRIVE_BIT);
        chk(oe_n, 1'b0);
        ticks(16);
        cfg((32'h1 << USMC_CLOCK_PIN_DRIVE_BIT) | (32'h3 << USMC_CLKSRC_LSB));
        chk(oe_n, 1'b1);
        peer_run <= 1'b1;
        ticks(0);
        peer_run <= 1'b0;
        cfg(32'h1 << USMC_CLKSRC_LSB);
        chk(oe_n, 1'b1);
        ticks(2);
        xfer(1'b1, USMC_OFS_WPROT, 32'h1);
        cfg(32'h40);
        rchk(USMC_OFS_LINE_CFG, 32'h10);
        xfer(1'b1, USMC_OFS_WPROT, 32'h0);
        cfg(32'h40);
        rchk(USMC_OFS_LINE_CFG, 32'h40);
        cfg(32'(USMC_MODE_SPI_M) | (32'h1 << USMC_ORDER_BIT));
        @(posedge clk);
        chk(sclk_out, 1'b1);
        cfg(32'(USMC_MODE_SPI_M));
        @(posedge clk);
        chk(sclk_out, 1'b0);
    endtask
    // main sequence
    initial begin
        {rstn, rd, wr, peer_run, adr, wdat, flags, bad_count, n_compared, cyc} = '0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        rchk(USMC_OFS_LINE_CFG, USMC_LINE_CFG_RST);
        t_mask();
        t_fields();
        t_clock();
        print_verdict();
    end
endmodule
